//--- rtl/bdm_defs.svh
// Constants of the bit, digit and block move unit.
// Assumes inclusion by the files of the unit that use its macros; definitions only.
`ifndef BDM_DEFS_SVH
`define BDM_DEFS_SVH

// Register byte offsets on the Wishbone slave
`define BDM_REG_CMD   8'h00
`define BDM_REG_CW    8'h04
`define BDM_REG_SRC   8'h08
`define BDM_REG_DST   8'h0C
`define BDM_REG_NUM   8'h10
`define BDM_REG_STAT  8'h14

// Command register fields
`define BDM_CMD_OP    1:0
`define BDM_CMD_GO    8

// Operation codes
`define BDM_OP_NIB    2'h0
`define BDM_OP_BIT    2'h1
`define BDM_OP_MULTI  2'h2
`define BDM_OP_BLOCK  2'h3

// Control word fields
`define BDM_NB_SRC    3:0
`define BDM_NB_CNT    7:4
`define BDM_NB_DST    11:8
`define BDM_NB_MAX    4'h3
`define BDM_BM_SRC    7:0
`define BDM_BM_DST    15:8
`define BDM_BM_MAX    8'h0F
`define BDM_BM_SPOS   3:0
`define BDM_BM_DPOS   11:8
`define BDM_MB_SRC    3:0
`define BDM_MB_DST    7:4
`define BDM_MB_CNT    15:8

// Reset values and small constants
`define BDM_RST16     16'h0000
`define BDM_ONE16     16'h0001
`define BDM_RST2      2'h0

`endif

//--- rtl/bdm_pkg.sv
// Types shared by the move unit.
// Assumes nothing beyond a SystemVerilog compiler.
package bdm_pkg;
  // Engine states; BDM_RD_SRC, BDM_RD_DST and BDM_WR each take one memory step
  typedef enum logic [2:0] {
    BDM_IDLE,
    BDM_RD_SRC,
    BDM_RD_DST,
    BDM_MERGE,
    BDM_WR
  } bdm_state_e;
endpackage

//--- rtl/bdm_nibble_merge.sv
// Nibble merge for the digit move.
// Assumes control fields already range checked by the caller.
`timescale 1ns/1ps
module bdm_nibble_merge (
  input  wire logic [15:0] src_i,       // Source word
  input  wire logic [15:0] dst_i,       // Old destination word
  input  wire logic [3:0]  first_src_i, // First source nibble
  input  wire logic [3:0]  cnt_m1_i,    // Nibbles minus one
  input  wire logic [3:0]  first_dst_i, // First destination nibble
  output logic      [15:0] word_o       // New destination word
);
  ////////////////////////////////////////////////////////////////
  // Walk up to four nibbles; 2-bit indices wrap to nibble 0
  always_comb begin
    logic [1:0] sn;
    logic [1:0] dn;
    sn = 2'h0;
    dn = 2'h0;
    word_o = dst_i;
    for (int k = 0; k < 4; k++) begin
      sn = 2'(first_src_i[1:0] + 2'(k));
      dn = 2'(first_dst_i[1:0] + 2'(k));
      // Only the counted nibbles change
      if (4'(k) <= cnt_m1_i) begin
        word_o[4*dn +: 4] = src_i[4*sn +: 4];
      end
    end
  end
endmodule

//--- rtl/bdm_bit_insert.sv
// Single bit insert into a word.
// Assumes a 16-bit word and a 4-bit position.
`timescale 1ns/1ps
`include "bdm_defs.svh"
module bdm_bit_insert (
  input  wire logic [15:0] word_i, // Old word
  input  wire logic [3:0]  pos_i,  // Bit position to replace
  input  wire logic        bit_i,  // New bit value
  output logic      [15:0] word_o  // Word with one bit replaced
);
  ////////////////////////////////////////////////////////////////
  // One-hot mask keeps every other bit as it was
  logic [15:0] mask_w; // Selected position
  assign mask_w = `BDM_ONE16 << pos_i;
  assign word_o = (word_i & ~mask_w) | (bit_i ? mask_w : `BDM_RST16);
endmodule

//--- rtl/bdm_move_unit.sv
// Bit, digit and block move unit with Wishbone registers.
// Assumes a synchronous word memory: read data one cycle after
// mem_re_o, write on the edge that sees mem_we_o.
//
// How it works
// - Digit move copies 4-bit nibbles
// - Source nibbles ascend, wrapping to nibble 0
// - Destination nibbles ascend, wrapping to nibble 0
// - Digit fields above 3 set error
// - Control 31 copies four, source 1, destination 0
// - Bit move changes only the chosen bit
// - Low byte source bit, high byte destination
// - Bit fields above 0F set error
// - Multi-bit moves up to 255 bits
// - Control holds source, destination start and count
// - Count zero writes nothing
// - Bits outside the run stay unchanged
// - Overlapping multi-word ranges are allowed
// - Block copies count words source to destination
// - Block count is unsigned 16 bits
// - Block ranges may overlap for shifting
// - Interrupts wait until block transfer ends
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "bdm_defs.svh"
module bdm_move_unit (
  input  wire logic        clk_i,            // 200 MHz clock
  input  wire logic        rst_i,            // Sync reset, high
  input  wire logic        wb_cyc_i,         // Bus cycle
  input  wire logic        wb_stb_i,         // Strobe
  input  wire logic        wb_we_i,          // Write
  input  wire logic [7:0]  wb_adr_i,         // Byte address
  input  wire logic [3:0]  wb_sel_i,         // Byte lanes
  input  wire logic [31:0] wb_dat_i,         // Write data
  output logic      [31:0] wb_dat_o,         // Read data
  output logic             wb_ack_o,         // Acknowledge
  output logic             mem_re_o,         // Memory read
  output logic             mem_we_o,         // Memory write
  output logic      [15:0] mem_addr_o,       // Word address
  output logic      [15:0] mem_wdata_o,      // Write word
  input  wire logic [15:0] mem_rdata_i,      // Read word
  input  wire logic        irq_req_i,        // Pending interrupt
  output logic             irq_grant_o,      // Interrupt may start
  output logic             busy_o,           // Operation running
  output logic             error_flag_out_o  // Error flag
);
  ////////////////////////////////////////////////////////////////
  // Software registers
  logic [1:0]  op_q;   // Operation code
  logic [15:0] cw_q;   // Control word
  logic [15:0] src_q;  // Source base word
  logic [15:0] dst_q;  // Destination base word
  logic [15:0] num_q;  // Block word count
  logic        go_q;   // Start pulse
  logic        ack_q;  // Bus acknowledge
  logic [31:0] rdat_q; // Read data
  logic        err_q;  // Error flag

  // Engine state
  bdm_pkg::bdm_state_e state_q; // Current step
  bdm_pkg::bdm_state_e state_d; // Next step
  logic [15:0] off_q;   // Element offset
  logic [15:0] rem_q;   // Elements left
  logic        desc_q;  // Copy from the top down
  logic [15:0] sw_q;    // Captured source word
  logic [15:0] wdat_q;  // Word to write

  ////////////////////////////////////////////////////////////////
  // Bus decode
  logic req_w;   // Request present
  logic wr_w;    // Write at the acknowledge edge
  logic idle_w;  // Engine idle
  logic hit_w;   // Mapped address
  assign req_w  = wb_cyc_i & wb_stb_i;
  assign wr_w   = req_w & wb_we_i & ack_q;
  assign idle_w = (state_q == bdm_pkg::BDM_IDLE);
  assign hit_w  = (wb_adr_i == `BDM_REG_CMD) | (wb_adr_i == `BDM_REG_CW) |
                  (wb_adr_i == `BDM_REG_SRC) | (wb_adr_i == `BDM_REG_DST) |
                  (wb_adr_i == `BDM_REG_NUM) | (wb_adr_i == `BDM_REG_STAT);

  // Byte lane merge for 16-bit registers
  function automatic logic [15:0] lanes(input logic [15:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    lanes = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  // Configuration is frozen while an operation runs
  logic wcfg_w; // Configuration write allowed
  assign wcfg_w = wr_w & idle_w;

  // Read mux; unmapped offsets read zero
  logic [31:0] rd_w; // Selected read word
  assign rd_w =
    (wb_adr_i == `BDM_REG_CMD)  ? {30'h0, op_q} :
    (wb_adr_i == `BDM_REG_CW)   ? {16'h0, cw_q} :
    (wb_adr_i == `BDM_REG_SRC)  ? {16'h0, src_q} :
    (wb_adr_i == `BDM_REG_DST)  ? {16'h0, dst_q} :
    (wb_adr_i == `BDM_REG_NUM)  ? {16'h0, num_q} :
    (wb_adr_i == `BDM_REG_STAT) ? {30'h0, err_q, ~idle_w} : 32'h0;

  ////////////////////////////////////////////////////////////////
  // Acknowledge one cycle after the request, drop the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= req_w & ~ack_q;
      rdat_q <= (hit_w & ~wb_we_i) ? rd_w : 32'h0;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  ////////////////////////////////////////////////////////////////
  // Register writes; start is refused while busy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_q  <= `BDM_RST2;
      cw_q  <= `BDM_RST16;
      src_q <= `BDM_RST16;
      dst_q <= `BDM_RST16;
      num_q <= `BDM_RST16;
      go_q  <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (wcfg_w && wb_adr_i == `BDM_REG_CMD && wb_sel_i[0]) begin
        op_q <= wb_dat_i[`BDM_CMD_OP];
      end
      if (wcfg_w && wb_adr_i == `BDM_REG_CMD && wb_sel_i[1]) begin
        go_q <= wb_dat_i[`BDM_CMD_GO];
      end
      if (wcfg_w && wb_adr_i == `BDM_REG_CW) begin
        cw_q <= lanes(cw_q, wb_dat_i, wb_sel_i);
      end
      if (wcfg_w && wb_adr_i == `BDM_REG_SRC) begin
        src_q <= lanes(src_q, wb_dat_i, wb_sel_i);
      end
      if (wcfg_w && wb_adr_i == `BDM_REG_DST) begin
        dst_q <= lanes(dst_q, wb_dat_i, wb_sel_i);
      end
      if (wcfg_w && wb_adr_i == `BDM_REG_NUM) begin
        num_q <= lanes(num_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Operation decode and range checks
  logic is_nib_w;   // Digit move
  logic is_bit_w;   // Single bit move
  logic is_mul_w;   // Multi-bit transfer
  logic is_blk_w;   // Block transfer
  logic nib_bad_w;  // Digit field out of range
  logic bit_bad_w;  // Bit field out of range
  logic [15:0] cnt_w; // Elements to move
  logic ok_w;       // Start accepted
  assign is_nib_w  = (op_q == `BDM_OP_NIB);
  assign is_bit_w  = (op_q == `BDM_OP_BIT);
  assign is_mul_w  = (op_q == `BDM_OP_MULTI);
  assign is_blk_w  = (op_q == `BDM_OP_BLOCK);
  assign nib_bad_w = (cw_q[`BDM_NB_SRC] > `BDM_NB_MAX) | (cw_q[`BDM_NB_CNT] > `BDM_NB_MAX) |
                     (cw_q[`BDM_NB_DST] > `BDM_NB_MAX);
  assign bit_bad_w = (cw_q[`BDM_BM_SRC] > `BDM_BM_MAX) |
                     (cw_q[`BDM_BM_DST] > `BDM_BM_MAX);
  // Byte count for bits, full word count for blocks
  assign cnt_w = is_blk_w ? num_q : {8'h0, cw_q[`BDM_MB_CNT]};
  assign ok_w  = (is_nib_w & ~nib_bad_w) | (is_bit_w & ~bit_bad_w) |
                 ((is_mul_w | is_blk_w) & (cnt_w != `BDM_RST16));

  ////////////////////////////////////////////////////////////////
  // Addresses: 20-bit bit addresses for the multi-bit run
  logic [19:0] sb0_w; // First source bit
  logic [19:0] db0_w; // First destination bit
  logic [19:0] sb_w;  // Current source bit
  logic [19:0] db_w;  // Current destination bit
  logic        dir_w; // Copy downward
  logic [15:0] sa_w;  // Source word address
  logic [15:0] da_w;  // Destination word address
  assign sb0_w = {src_q, 4'h0} + {16'h0, cw_q[`BDM_MB_SRC]};
  assign db0_w = {dst_q, 4'h0} + {16'h0, cw_q[`BDM_MB_DST]};
  assign sb_w  = sb0_w + {4'h0, off_q};
  assign db_w  = db0_w + {4'h0, off_q};
  // Destination above source must copy from the top, else bottom
  assign dir_w = is_blk_w ? (dst_q > src_q) : (db0_w > sb0_w);
  assign sa_w  = is_mul_w ? sb_w[19:4] : 16'(src_q + off_q);
  assign da_w  = is_mul_w ? db_w[19:4] : 16'(dst_q + off_q);

  ////////////////////////////////////////////////////////////////
  // Merge of the new destination word
  logic [15:0] nib_w;  // Digit move result
  logic [15:0] ins_w;  // Bit move result
  logic [3:0]  ipos_w; // Destination bit
  logic        ibit_w; // Copied bit
  logic [15:0] mrg_w;  // Word to write
  assign ipos_w = is_bit_w ? cw_q[`BDM_BM_DPOS] : db_w[3:0];
  assign ibit_w = is_bit_w ? sw_q[cw_q[`BDM_BM_SPOS]] : sw_q[sb_w[3:0]];
  assign mrg_w  = is_blk_w ? mem_rdata_i : (is_nib_w ? nib_w : ins_w);

  // Fields: start source, count minus one, start destination
  bdm_nibble_merge u_nib (
    .src_i       (sw_q),
    .dst_i       (mem_rdata_i),
    .first_src_i (cw_q[`BDM_NB_SRC]),
    .cnt_m1_i    (cw_q[`BDM_NB_CNT]),
    .first_dst_i (cw_q[`BDM_NB_DST]),
    .word_o      (nib_w)
  );

  // Shared by single bit and multi-bit moves
  bdm_bit_insert u_ins (
    .word_i (mem_rdata_i),
    .pos_i  (ipos_w),
    .bit_i  (ibit_w),
    .word_o (ins_w)
  );

  ////////////////////////////////////////////////////////////////
  // Step sequencing; a block skips the destination read
  always_comb begin
    case (state_q)
      bdm_pkg::BDM_IDLE:   state_d = (go_q & ok_w) ? bdm_pkg::BDM_RD_SRC : bdm_pkg::BDM_IDLE;
      bdm_pkg::BDM_RD_SRC: state_d = is_blk_w ? bdm_pkg::BDM_MERGE : bdm_pkg::BDM_RD_DST;
      bdm_pkg::BDM_RD_DST: state_d = bdm_pkg::BDM_MERGE;
      bdm_pkg::BDM_MERGE:  state_d = bdm_pkg::BDM_WR;
      bdm_pkg::BDM_WR:     state_d = (rem_q == `BDM_ONE16) ? bdm_pkg::BDM_IDLE : bdm_pkg::BDM_RD_SRC;
      default:             state_d = bdm_pkg::BDM_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Engine registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= bdm_pkg::BDM_IDLE;
      off_q   <= `BDM_RST16;
      rem_q   <= `BDM_RST16;
      desc_q  <= 1'b0;
      sw_q    <= `BDM_RST16;
      wdat_q  <= `BDM_RST16;
      err_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      // Start: set or clear the flag, load the walk
      if (idle_w && go_q) begin
        err_q  <= (is_nib_w & nib_bad_w) | (is_bit_w & bit_bad_w);
        desc_q <= dir_w & (is_mul_w | is_blk_w);
        off_q  <= (dir_w & (is_mul_w | is_blk_w)) ? 16'(cnt_w - `BDM_ONE16) : `BDM_RST16;
        rem_q  <= (is_mul_w | is_blk_w) ? cnt_w : `BDM_ONE16;
      end
      // Source word arrives the cycle after its read
      if (state_q == bdm_pkg::BDM_RD_DST) begin
        sw_q <= mem_rdata_i;
      end
      if (state_q == bdm_pkg::BDM_MERGE) begin
        wdat_q <= mrg_w;
      end
      // Advance one element after each write
      if (state_q == bdm_pkg::BDM_WR) begin
        off_q <= desc_q ? 16'(off_q - `BDM_ONE16) : 16'(off_q + `BDM_ONE16);
        rem_q <= 16'(rem_q - `BDM_ONE16);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Memory and status outputs
  assign mem_re_o    = (state_q == bdm_pkg::BDM_RD_SRC) | (state_q == bdm_pkg::BDM_RD_DST);
  assign mem_we_o    = (state_q == bdm_pkg::BDM_WR);
  assign mem_addr_o  = (state_q == bdm_pkg::BDM_RD_SRC) ? sa_w : da_w;
  assign mem_wdata_o = wdat_q;
  assign busy_o      = ~idle_w;
  assign error_flag_out_o = err_q;
  // A block transfer holds off interrupts until its last write
  assign irq_grant_o = irq_req_i & ~(busy_o & is_blk_w);

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic start_w; // Start seen while idle
  assign start_w = go_q & idle_w;

  property p_nib_err;
    start_w && is_nib_w && nib_bad_w |=> err_q && idle_w;
  endproperty
  a_nib_err: assert property (p_nib_err) else $error("digit error not flagged");

  property p_bit_err;
    start_w && is_bit_w && bit_bad_w |=> err_q ##1 !mem_we_o;
  endproperty
  a_bit_err: assert property (p_bit_err) else $error("bit error not flagged");

  property p_word_block_transfer_op_clr;
    start_w && (is_mul_w || is_blk_w) |=> !err_q;
  endproperty
  a_word_block_transfer_op_clr: assert property (p_word_block_transfer_op_clr) else $error("error flag left set");

  property p_zero_cnt;
    start_w && is_mul_w && cw_q[`BDM_MB_CNT] == 8'h00 |=> !mem_we_o [*3];
  endproperty
  a_zero_cnt: assert property (p_zero_cnt) else $error("write on zero count");

  sequence s_dst_path;
    mem_re_o ##1 (state_q == bdm_pkg::BDM_MERGE) ##1 mem_we_o;
  endsequence
  property p_dst_path;
    state_q == bdm_pkg::BDM_RD_DST |-> s_dst_path;
  endproperty
  a_dst_path: assert property (p_dst_path) else $error("merge step skipped");

  property p_bit_keep;
    state_q == bdm_pkg::BDM_MERGE && is_bit_w |=>
      ((mem_wdata_o ^ $past(mem_rdata_i)) & ~(`BDM_ONE16 << cw_q[`BDM_BM_DPOS])) == `BDM_RST16;
  endproperty
  a_bit_keep: assert property (p_bit_keep) else $error("other bit changed");

  property p_irq_hold;
    busy_o && is_blk_w |-> !irq_grant_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt during block");

  property p_blk_copy;
    state_q == bdm_pkg::BDM_MERGE && is_blk_w |=> mem_we_o && mem_wdata_o == $past(mem_rdata_i);
  endproperty
  a_blk_copy: assert property (p_blk_copy) else $error("block word not copied");
endmodule

//--- tb/test_bdm_move_unit.sv
// Self-checking bench of the bit, digit and block move unit.
// Assumes the unit's register map and a 1-cycle synchronous word memory.
`timescale 1ns/1ps
`include "bdm_defs.svh"
`define CHECK_EQ(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module test_bdm_move_unit;
  ////////////////////////////////////////////////////////////////////////
  // One table row: operation, operands, memory before and after
  typedef struct {
    logic [1:0]  op;
    logic [15:0] cw, sb, db, num, s0, s1, d0, d1, e0, e1;
    logic        err;
  } bdm_row_s;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;  // Clock, reset, bus
  logic [7:0]  wb_adr_i;                                   // Byte address
  logic [3:0]  wb_sel_i;                                   // Byte lanes
  logic [31:0] wb_dat_i, wb_dat_o, rd;                     // Bus data
  logic        wb_ack_o, mem_re_o, mem_we_o;               // Handshakes
  logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i;       // Memory port
  logic        irq_req_i, irq_grant_o, busy_o, error_flag_out_o;
  logic [15:0] mem [0:255];                                // Word memory model
  int          miscompares, comparisons;                   // Verdict counters
  bdm_row_s    rows [17];                                  // Ordinary cases
  bdm_move_unit uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_re_o(mem_re_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
    .irq_req_i(irq_req_i), .irq_grant_o(irq_grant_o), .busy_o(busy_o),
    .error_flag_out_o(error_flag_out_o));
  ////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Memory: write on the edge, read data one cycle on; idle data toggles
  // so a stale read can never pass for a fresh one
  always @(posedge clk_i) begin
    if (mem_we_o) mem[mem_addr_o[7:0]] <= mem_wdata_o;
    if (rst_i) mem_rdata_i <= 16'h0000;
    else mem_rdata_i <= mem_re_o ? mem[mem_addr_o[7:0]] : ~mem_rdata_i;
  end
  ////////////////////////////////////////////////////////////////////////
  // Closing report, the single exit
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= adr; wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      stop_test();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Bounded wait for the engine to go idle
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge clk_i);
    while (busy_o !== 1'b0 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    if (busy_o !== 1'b0) begin
      miscompares++;
      stop_test();
    end
    repeat (2) @(posedge clk_i);
  endtask
  // Load operands, then op and go in one write
  // Every range stays inside the 256-word model area
  task automatic run(input logic [1:0] op, input logic [15:0] cw, sb, db, num);
    wb(1'b1, `BDM_REG_SRC, {16'h0000, sb});
    wb(1'b1, `BDM_REG_DST, {16'h0000, db});
    wb(1'b1, `BDM_REG_NUM, {16'h0000, num});
    wb(1'b1, `BDM_REG_CW, {16'h0000, cw});
    wb(1'b1, `BDM_REG_CMD, {23'h000000, 1'b1, 6'h00, op});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 8'h00;
    wb_sel_i = 4'hF; wb_dat_i = 32'h00000000; irq_req_i = 1'b0;
    miscompares = 0; comparisons = 0;
    // op, cw, src base, dst base, count, src words, dst words, expected, error
    // Last two rows copy from the bottom up over overlapping ranges
    rows = '{
      '{2'h0, 16'h0031, 16'h0010, 16'h0020, 16'h0000, 16'h1234, 16'h0000, 16'hABCD, 16'h5555, 16'h4123, 16'h5555, 1'b0},
      '{2'h0, 16'h0000, 16'h0010, 16'h0020, 16'h0000, 16'h1234, 16'h0000, 16'hABCD, 16'h5555, 16'hABC4, 16'h5555, 1'b0},
      '{2'h0, 16'h0123, 16'h0010, 16'h0020, 16'h0000, 16'h1234, 16'h0000, 16'hABCD, 16'h5555, 16'h341D, 16'h5555, 1'b0},
      '{2'h0, 16'h0004, 16'h0010, 16'h0020, 16'h0000, 16'h1234, 16'h0000, 16'hABCD, 16'h5555, 16'hABCD, 16'h5555, 1'b1},
      '{2'h0, 16'h0400, 16'h0010, 16'h0020, 16'h0000, 16'h1234, 16'h0000, 16'hABCD, 16'h5555, 16'hABCD, 16'h5555, 1'b1},
      '{2'h1, 16'h0C05, 16'h0010, 16'h0020, 16'h0000, 16'h0020, 16'h0000, 16'h0000, 16'h5555, 16'h1000, 16'h5555, 1'b0},
      '{2'h1, 16'h0C05, 16'h0010, 16'h0020, 16'h0000, 16'hFFDF, 16'h0000, 16'hFFFF, 16'h5555, 16'hEFFF, 16'h5555, 1'b0},
      '{2'h1, 16'h1005, 16'h0010, 16'h0020, 16'h0000, 16'h0020, 16'h0000, 16'hABCD, 16'h5555, 16'hABCD, 16'h5555, 1'b1},
      '{2'h2, 16'h0000, 16'h0010, 16'h0020, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hABCD, 16'h5555, 16'hABCD, 16'h5555, 1'b0},
      '{2'h1, 16'h0C10, 16'h0010, 16'h0020, 16'h0000, 16'h0020, 16'h0000, 16'hABCD, 16'h5555, 16'hABCD, 16'h5555, 1'b1},
      '{2'h2, 16'h0462, 16'h0010, 16'h0020, 16'h0000, 16'h003C, 16'h0000, 16'h0000, 16'h5555, 16'h03C0, 16'h5555, 1'b0},
      '{2'h2, 16'h120E, 16'h0010, 16'h0020, 16'h0000, 16'h8000, 16'h1234, 16'h0000, 16'hFFFF, 16'h48D2, 16'hFFFC, 1'b0},
      '{2'h2, 16'h0840, 16'h0020, 16'h0020, 16'h0000, 16'h00AB, 16'h0000, 16'h00AB, 16'h0000, 16'h0ABB, 16'h0000, 1'b0},
      '{2'h3, 16'h0000, 16'h0010, 16'h0020, 16'h0002, 16'h1111, 16'h2222, 16'h0000, 16'h0000, 16'h1111, 16'h2222, 1'b0},
      '{2'h3, 16'h0000, 16'h0010, 16'h0020, 16'h0000, 16'h1111, 16'h2222, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0},
      '{2'h2, 16'h0804, 16'h0020, 16'h0020, 16'h0000, 16'h0ABC, 16'h0000, 16'h0ABC, 16'h0000, 16'h0AAB, 16'h0000, 1'b0},
      '{2'h3, 16'h0000, 16'h0041, 16'h0040, 16'h0002, 16'h1111, 16'h2222, 16'h0000, 16'h1111, 16'h1111, 16'h2222, 1'b0}};
    // Reset held for 12 cycles, first request a cycle after release
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `BDM_REG_STAT, 32'h00000000);
    `CHECK_EQ("status after reset", 32'h00000000, rd)
    wb(1'b0, 8'h40, 32'h00000000);
    `CHECK_EQ("unmapped read", 32'h00000000, rd)
    wb(1'b1, `BDM_REG_NUM, 32'h0000FFFF);
    wb(1'b0, `BDM_REG_NUM, 32'h00000000);
    `CHECK_EQ("full block count", 32'h0000FFFF, rd)
    // Low byte lane only: high byte keeps its value
    wb_sel_i <= 4'h1;
    wb(1'b1, `BDM_REG_NUM, 32'h00001234);
    wb_sel_i <= 4'hF;
    wb(1'b0, `BDM_REG_NUM, 32'h00000000);
    `CHECK_EQ("low lane only", 32'h0000FF34, rd)
    // Table of ordinary cases
    foreach (rows[i]) begin
      mem[rows[i].sb[7:0]] = rows[i].s0;
      mem[rows[i].sb[7:0] + 8'h01] = rows[i].s1;
      mem[rows[i].db[7:0]] = rows[i].d0;
      mem[rows[i].db[7:0] + 8'h01] = rows[i].d1;
      run(rows[i].op, rows[i].cw, rows[i].sb, rows[i].db, rows[i].num);
      wait_idle();
      `CHECK_EQ("first destination", rows[i].e0, mem[rows[i].db[7:0]])
      `CHECK_EQ("second destination", rows[i].e1, mem[rows[i].db[7:0] + 8'h01])
      `CHECK_EQ("error flag", rows[i].err, error_flag_out_o)
      wb(1'b0, `BDM_REG_STAT, 32'h00000000);
      `CHECK_EQ("status error", rows[i].err, rd[1])
    end
    // Overlapping block shift up by one with a pending interrupt
    mem[8'h30] = 16'hA1A1; mem[8'h31] = 16'hB2B2; mem[8'h32] = 16'hC3C3; mem[8'h33] = 16'hD4D4;
    irq_req_i <= 1'b1;
    run(2'h3, 16'h0000, 16'h0030, 16'h0031, 16'h0003);
    repeat (3) @(posedge clk_i);
    `CHECK_EQ("busy during block", 1'b1, busy_o)
    `CHECK_EQ("grant held off", 1'b0, irq_grant_o)
    wb(1'b1, `BDM_REG_SRC, 32'h00000050);
    wait_idle();
    `CHECK_EQ("grant after block", 1'b1, irq_grant_o)
    `CHECK_EQ("shift word 1", 16'hA1A1, mem[8'h31])
    `CHECK_EQ("shift word 2", 16'hB2B2, mem[8'h32])
    `CHECK_EQ("shift word 3", 16'hC3C3, mem[8'h33])
    `CHECK_EQ("base word kept", 16'hA1A1, mem[8'h30])
    wb(1'b0, `BDM_REG_SRC, 32'h00000000);
    `CHECK_EQ("write while busy ignored", 32'h00000030, rd)
    // Reset in mid-transfer: engine stops and registers clear
    run(2'h3, 16'h0000, 16'h0030, 16'h0031, 16'h0003);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHECK_EQ("busy after reset", 1'b0, busy_o)
    wb(1'b0, `BDM_REG_NUM, 32'h00000000);
    `CHECK_EQ("count after reset", 32'h00000000, rd)
    irq_req_i <= 1'b0;
    @(posedge clk_i);
    stop_test();
  end
endmodule
